// ---- design/frequency_sweep_controller.sv ----
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module frequency_sweep_controller
    import sweep_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_trig,
    output logic      [FW-1:0] freq_out,
    output logic      [31:0] phase_out,
    output logic             trig_wait_lamp,
    output logic             irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic            en;
        logic            log_sp;
        logic [1:0]      src;
        logic [2:0]      shape;
        logic [1:0]      mod;
        logic [FW-1:0]   f_begin;
        logic [FW-1:0]   f_end;
        logic [18:0]     t_ms;
        sweep_st_e       st;
        logic [FW-1:0]   freq;
        logic [FW-1:0]   inc;
        logic [18:0]     step;
        logic [23:0]     tick;
        logic [31:0]     phase;
        logic            ext_q;
        logic            bus_pend;
        logic            wai;
        logic            opc_arm;
        logic [4:0]      stat;
        logic [4:0]      mask;
        logic [31:0]     rdata;
    } state_s;

    state_s r, n;

    logic [FW-1:0] beg_c, end_c;
    logic          slow;
    logic          wr, rd, up, tick_hit, last, trig, done;
    logic [FW-1:0] span;
    logic [4:0]    ev;
    logic [FW+15:0] prod;

    assign slow = (r.shape == SH_TRI) || (r.shape == SH_RAMP);

    freq_clamp u_clamp_b (
        .raw        (r.f_begin),
        .slow_shape (slow),
        .clamped    (beg_c)
    );
    freq_clamp u_clamp_e (
        .raw        (r.f_end),
        .slow_shape (slow),
        .clamped    (end_c)
    );

    // Command port stalls while a wait is pending
    assign pready  = !r.wai;
    assign pslverr = 1'b0;
    assign wr = psel && penable && pwrite && pready;
    assign rd = psel && !pwrite;
    assign up = beg_c < end_c;
    assign span = up ? end_c - beg_c : beg_c - end_c;
    assign tick_hit = r.tick == 24'(STEP_CYC - 1);
    assign last = r.step >= r.t_ms;
    assign done = (r.st == ST_RUN) && r.en && tick_hit && last;
    // Log ratio step: f * (1 +/- span/(beg_c*steps)) approximated per step
    assign prod = {16'h0000, r.freq} * 16'(r.inc[15:0]);

    always_comb begin
        n = r;
        ev = 5'h00;
        n.ext_q = ext_trig;
        n.tick = tick_hit ? 24'h00_0000 : r.tick + 24'h00_0001;
        // --------------------------------------------------------
        // Register writes
        // --------------------------------------------------------
        if (wr) begin
            unique case (paddr)
                A_CTRL: begin
                    n.en = pwdata[C_EN];
                    n.log_sp = pwdata[C_LOG];
                    n.src = pwdata[C_SRC +: 2];
                    n.shape = pwdata[C_SHAPE +: 3];
                    n.mod = pwdata[C_MOD +: 2];
                    if (pwdata[C_EN]) begin
                        n.mod = 2'b00;
                    end
                end
                A_BEGIN: n.f_begin[31:0] = pwdata;
                A_BEGINH: n.f_begin[FW-1:32] = pwdata[FW-33:0];
                A_END: n.f_end[31:0] = pwdata;
                A_ENDH: n.f_end[FW-1:32] = pwdata[FW-33:0];
                A_TIME: begin
                    if (pwdata[18:0] < T_MIN_MS) begin
                        n.t_ms = T_MIN_MS;
                    end else if (pwdata[31:0] > {13'h0, T_MAX_MS}) begin
                        n.t_ms = T_MAX_MS;
                    end else begin
                        n.t_ms = pwdata[18:0];
                    end
                end
                A_CMD: begin
                    if (pwdata[K_TRG] && r.src == SRC_BUS) begin
                        n.bus_pend = 1'b1;
                    end
                    if (pwdata[K_WAI] && r.st != ST_IDLE &&
                        (r.bus_pend || r.st == ST_RUN)) begin
                        n.wai = 1'b1;
                    end
                    if (pwdata[K_OPC]) begin
                        n.opc_arm = 1'b1;
                    end
                    if (pwdata[K_COMBINED_SETUP_CMD]) begin
                        n.src = SRC_INT;
                    end
                end
                A_STAT: n.stat = r.stat & ~pwdata[4:0];
                A_IMASK: n.mask = pwdata[4:0];
                default: ;
            endcase
        end
        // --------------------------------------------------------
        // Sweep engine
        // --------------------------------------------------------
        trig = 1'b0;
        unique case (r.src)
            SRC_EXT: trig = ext_trig && !r.ext_q;
            SRC_BUS: trig = r.bus_pend;
            default: trig = 1'b1;
        endcase
        n.phase = r.phase + r.freq[31:0];
        unique case (r.st)
            ST_IDLE: begin
                n.freq = beg_c;
                if (r.en) begin
                    n.st = ST_ARMED;
                end
            end
            ST_ARMED: begin
                n.freq = beg_c;
                if (!r.en) begin
                    n.st = ST_IDLE;
                end else if (trig) begin
                    n.st = ST_RUN;
                    n.step = 19'h0_0000;
                    n.bus_pend = 1'b0;
                    n.tick = 24'h00_0000;
                    ev[S_TRIG] = 1'b1;
                    // Per-step increment from duration
                    n.inc = span / FW'(r.t_ms);
                    if (r.log_sp) begin
                        n.inc = FW'(16'h0001) + FW'(span[FW-1:0] /
                            (beg_c * FW'(r.t_ms) / FW'(16'h4000) + 1'b1));
                    end
                end
            end
            ST_RUN: begin
                if (!r.en) begin
                    n.st = ST_IDLE;
                end else if (tick_hit) begin
                    n.step = r.step + 19'h0_0001;
                    if (r.log_sp) begin
                        // Constant ratio per step
                        n.freq = up ? r.freq + FW'(prod >> 14)
                                    : r.freq - FW'(prod >> 14);
                    end else begin
                        n.freq = up ? r.freq + r.inc : r.freq - r.inc;
                    end
                    if ((up && n.freq > end_c) ||
                        (!up && n.freq < end_c)) begin
                        n.freq = end_c;
                    end
                    if (last) begin
                        n.st = ST_ARMED;
                        n.freq = beg_c;
                        n.wai = 1'b0;
                        ev[S_DONE] = 1'b1;
                        if (r.opc_arm) begin
                            ev[S_OPC] = 1'b1;
                            n.opc_arm = 1'b0;
                        end
                    end
                end
            end
            default: n.st = ST_IDLE;
        endcase
        // Sticky status bits 0-2, set wins over clear; bits 3 and 4 follow the state
        n.stat = n.stat | ev;
        n.stat[S_WAIT] = (r.st == ST_ARMED) && (r.src == SRC_EXT);
        n.stat[S_OPCQ] = r.st != ST_RUN;
        n.rdata = 32'h0000_0000;
        if (rd) begin
            unique case (paddr)
                A_CTRL: n.rdata = {22'h0, r.mod, 1'b0, r.shape,
                                   r.src, r.log_sp, r.en};
                A_BEGIN: n.rdata = beg_c[31:0];
                A_BEGINH: n.rdata = {29'h0, beg_c[FW-1:32]};
                A_END: n.rdata = end_c[31:0];
                A_ENDH: n.rdata = {29'h0, end_c[FW-1:32]};
                A_TIME: n.rdata = {13'h0, r.t_ms};
                A_STAT: n.rdata = {27'h0, r.stat};
                A_IMASK: n.rdata = {27'h0, r.mask};
                A_FREQ: n.rdata = r.freq[31:0];
                A_PHASE: n.rdata = r.phase;
                default: n.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.f_begin <= F_BEGIN_RST;
            r.f_end <= F_END_RST;
            r.t_ms <= T_RST_MS;
            r.st <= ST_IDLE;
            r.stat <= 5'h10;
        end else begin
            r <= n;
        end
    end

    // Read data registered on every selected read cycle, setup and access alike, so it is refreshed while an access stalls
    assign prdata = r.rdata;
    assign freq_out = r.freq;
    assign phase_out = r.phase;
    assign trig_wait_lamp = r.stat[S_WAIT];
    assign irq = |(r.stat[2:0] & r.mask[2:0]);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_mod_off;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == A_CTRL && pwdata[C_EN]) |=> r.mod == 2'b00;
    endproperty
    a_mod_off: assert property (p_mod_off)
        else $error("modulation left on with sweep");

    property p_combined_setup_cmd;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == A_CMD && pwdata[K_COMBINED_SETUP_CMD]) |=> r.src == SRC_INT;
    endproperty
    a_combined_setup_cmd: assert property (p_combined_setup_cmd)
        else $error("setup did not force internal source");

    property p_hold_begin;
        @(posedge pclk) disable iff (!presetn)
        (r.st == ST_ARMED) |-> r.freq == $past(beg_c);
    endproperty
    a_hold_begin: assert property (p_hold_begin)
        else $error("armed without begin frequency");

    property p_clamp;
        @(posedge pclk) disable iff (!presetn)
        slow |-> (beg_c <= F_TRI_MAX && end_c <= F_TRI_MAX);
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("slow shape endpoint above limit");

    property p_phase;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> r.phase == $past(r.phase) + $past(r.freq[31:0]);
    endproperty
    a_phase: assert property (p_phase)
        else $error("phase jump");

    property p_opc;
        @(posedge pclk) disable iff (!presetn)
        (done && r.opc_arm) |=> r.stat[S_OPC];
    endproperty
    a_opc: assert property (p_opc)
        else $error("operation complete not set");

    property p_ext;
        @(posedge pclk) disable iff (!presetn)
        (r.st == ST_ARMED && r.en && r.src == SRC_EXT && ext_trig
         && !r.ext_q) |=> r.st == ST_RUN;
    endproperty
    a_ext: assert property (p_ext)
        else $error("external edge missed");

    property p_dir;
        @(posedge pclk) disable iff (!presetn)
        (r.st == ST_RUN && $past(r.st) == ST_RUN && up)
            |-> r.freq >= $past(r.freq);
    endproperty
    a_dir: assert property (p_dir)
        else $error("upward sweep fell");

    property p_wai;
        @(posedge pclk) disable iff (!presetn)
        r.wai |-> r.st != ST_IDLE;
    endproperty
    a_wai: assert property (p_wai)
        else $error("wait held with nothing pending");

    property p_down;
        @(posedge pclk) disable iff (!presetn)
        (r.st == ST_RUN && $past(r.st) == ST_RUN && !up)
            |-> r.freq <= $past(r.freq);
    endproperty
    a_down: assert property (p_down)
        else $error("downward sweep rose");

    property p_lamp;
        @(posedge pclk) disable iff (!presetn)
        (r.st == ST_ARMED && r.src == SRC_EXT) |=> trig_wait_lamp;
    endproperty
    a_lamp: assert property (p_lamp)
        else $error("waiting lamp dark while armed");

    property p_bus;
        @(posedge pclk) disable iff (!presetn)
        (r.st == ST_ARMED && r.en && r.src == SRC_BUS && r.bus_pend)
            |=> r.st == ST_RUN;
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus trigger did not start sweep");

    property p_stall;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == A_CMD && pwdata[K_WAI] && r.st == ST_RUN && !done)
            |=> !pready;
    endproperty
    a_stall: assert property (p_stall)
        else $error("wait command did not stall the port");

    c_done: cover property (@(posedge pclk) done);
    c_log: cover property (@(posedge pclk) done && r.log_sp);
    c_bus: cover property (@(posedge pclk)
        r.src == SRC_BUS && r.st == ST_RUN);
    c_wai: cover property (@(posedge pclk) r.wai ##1 !r.wai);
endmodule : frequency_sweep_controller

// ---- shared/sweep_pkg.sv ----
// Function
// - Begin frequency 10 mHz to 15 MHz, default 100 Hz
// - End frequency same range, default 1 kHz
// - Triangle or ramp limits endpoints to 100 kHz
// - Phase accumulator never reset between steps
// - Direction follows which endpoint is larger
// - Linear or log spacing, linear default, readable
// - Duration 1 ms to 500 s, default 1 s
// - Step count derived internally from duration
// - Sweep enable turns other modulation off
// - Enable reads back as 0 or 1
// - Triggered: one sweep, then hold begin frequency
// - Internal source repeats sweeps continuously
// - External rising edge starts sweep, waiting lamp
// - Bus trigger command gives one sweep each
// - Wait command holds until sweep finishes
// - Completion sets operation complete bit 0
// - Combined setup forces internal; source readable
package sweep_pkg;
    // Frequencies in millihertz, 35 bits
    localparam int FW = 35;
    localparam logic [FW-1:0] F_MIN     = 35'h0_0000_000a;
    localparam logic [FW-1:0] F_MAX     = 35'h3_7e11_d600;
    localparam logic [FW-1:0] F_TRI_MAX = 35'h0_05f5_e100;
    localparam logic [FW-1:0] F_BEGIN_RST = 35'h0_0001_86a0;
    localparam logic [FW-1:0] F_END_RST   = 35'h0_000f_4240;
    // Duration in milliseconds
    localparam logic [18:0] T_MIN_MS = 19'h0_0001;
    localparam logic [18:0] T_MAX_MS = 19'h7_a120;
    localparam logic [18:0] T_RST_MS = 19'h0_03e8;
    // One step per millisecond at 100 MHz
    localparam int CLK_MHZ = 100;
    localparam int STEP_NS = 1000000;
    localparam int STEP_CYC = STEP_NS * CLK_MHZ / 1000;
    // Register byte offsets
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_BEGIN  = 8'h04;
    localparam logic [7:0] A_END    = 8'h08;
    localparam logic [7:0] A_TIME   = 8'h0c;
    localparam logic [7:0] A_CMD    = 8'h10;
    localparam logic [7:0] A_STAT   = 8'h14;
    localparam logic [7:0] A_IMASK  = 8'h18;
    localparam logic [7:0] A_FREQ   = 8'h1c;
    localparam logic [7:0] A_PHASE  = 8'h20;
    localparam logic [7:0] A_BEGINH = 8'h24;
    localparam logic [7:0] A_ENDH   = 8'h28;
    // Control fields
    localparam int C_EN = 0;
    localparam int C_LOG = 1;
    localparam int C_SRC = 2;   // 2 bits
    localparam int C_SHAPE = 4; // 3 bits
    localparam int C_MOD = 8;   // 2 bits, other modulation
    // Command bits (write one)
    localparam int K_TRG = 0;
    localparam int K_WAI = 1;
    localparam int K_OPC = 2;
    localparam int K_COMBINED_SETUP_CMD = 3;
    // Status bits
    localparam int S_OPC = 0;
    localparam int S_DONE = 1;
    localparam int S_TRIG = 2;
    localparam int S_WAIT = 3;
    localparam int S_OPCQ = 4;
    typedef enum logic [1:0] {
        SRC_INT = 2'b00, SRC_EXT = 2'b01, SRC_BUS = 2'b10
    } src_e;
    typedef enum logic [2:0] {
        SH_SINE = 3'b000, SH_SQUARE = 3'b001, SH_TRI = 3'b010,
        SH_RAMP = 3'b011, SH_ARB = 3'b100
    } shape_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_ARMED = 2'b01, ST_RUN = 2'b10
    } sweep_st_e;
endpackage : sweep_pkg

// ---- design/freq_clamp.sv ----
`timescale 1ns/1ps
module freq_clamp
    import sweep_pkg::*;
(
    input  wire logic [FW-1:0] raw,
    input  wire logic          slow_shape,
    output logic      [FW-1:0] clamped
);
    logic [FW-1:0] top;
    always_comb begin
        top = slow_shape ? F_TRI_MAX : F_MAX;
        if (raw < F_MIN) begin
            clamped = F_MIN;
        end else if (raw > top) begin
            clamped = top;
        end else begin
            clamped = raw;
        end
    end
endmodule : freq_clamp

// ---- sim/trig_source.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// External trigger source
// ----------------------------------------
module trig_source #(
    parameter int DLY = 3,
    parameter int HI  = 4
) (
    input  wire logic pclk,
    input  wire logic fire,
    output logic      ext_trig
);
    initial ext_trig = 1'b0;
    // Delayed rising edge, then high for HI clocks and low again
    always @(posedge pclk) begin
        if (fire) begin
            repeat (DLY) @(posedge pclk);
            ext_trig <= 1'b1;
            repeat (HI) @(posedge pclk);
            ext_trig <= 1'b0;
        end
    end
endmodule : trig_source

// ---- sim/frequency_sweep_controller_tb_top.sv ----
`timescale 1ns/1ps
module frequency_sweep_controller_tb_top
    import sweep_pkg::*;
;
    logic          pclk, presetn, psel, penable, pwrite, ext_fire;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, phase_out, v;
    logic          pready, pslverr, ext_trig, trig_wait_lamp, irq;
    logic [FW-1:0] freq_out;
    logic [71:0]   exp_q[$];
    logic [71:0]   e;
    int            fail_count, n_tests, cyc, c0;

    frequency_sweep_controller frequency_sweep_controller_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_trig, .freq_out, .phase_out,
        .trig_wait_lamp, .irq
    );
    trig_source trig_source_inst (.pclk, .fire(ext_fire), .ext_trig);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ----------------------------------------
    // Compare and report
    // ----------------------------------------
    task automatic cmp_pin(input string nm, input logic [34:0] ev,
                           input logic [34:0] s);
        n_tests++;
        if (s !== ev) begin
            fail_count++;
            $display("ERROR %s exp %h got %h", nm, ev, s);
        end
    endtask : cmp_pin

    task automatic cmp_rd(input logic [71:0] x, input logic [31:0] s);
        n_tests++;
        if ((s & x[63:32]) !== (x[31:0] & x[63:32])) begin
            fail_count++;
            $display("ERROR reg %h exp %h got %h", x[71:64], x[31:0], s);
        end
    endtask : cmp_rd

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // Read results taken at the completing edge
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite
            && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            cmp_rd(e, prdata);
        end
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 300000) begin
            fail_count++;
            final_report();
        end
    end

    // ----------------------------------------
    // APB master
    // ----------------------------------------
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] ev);
        exp_q.push_back({a, m, ev});
        apb(1'b0, a, 32'h0);
    endtask : rd

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        presetn  = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 8'h00;
        pwdata   = 32'h0;
        ext_fire = 1'b0;
        v = $urandom(56);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        cmp_pin("freq_out", F_BEGIN_RST, freq_out);
        rd(A_CTRL, 32'h3ff, 32'h0);
        rd(A_BEGIN, '1, F_BEGIN_RST[31:0]);
        rd(A_END, '1, F_END_RST[31:0]);
        rd(A_TIME, '1, {13'h0, T_RST_MS});
        rd(8'h3c, '1, 32'h0);
        v = 32'd10 + ($urandom % 32'd1000000);
        wr(A_BEGINH, 32'h0);
        wr(A_BEGIN, v);
        rd(A_BEGIN, '1, v);
        wr(A_BEGINH, 32'h7);
        wr(A_BEGIN, '1);
        rd(A_BEGIN, '1, F_MAX[31:0]);
        rd(A_BEGINH, 32'h7, {29'h0, F_MAX[34:32]});
        wr(A_END, 32'h0);
        rd(A_END, '1, F_MIN[31:0]);
        wr(A_CTRL, 32'h20);
        rd(A_BEGIN, '1, F_TRI_MAX[31:0]);
        wr(A_CTRL, 32'h30);
        rd(A_BEGIN, '1, F_TRI_MAX[31:0]);
        wr(A_TIME, 32'h0);
        rd(A_TIME, '1, 32'h1);
        wr(A_TIME, '1);
        rd(A_TIME, '1, {13'h0, T_MAX_MS});
        for (int i = 0; i < 3; i++) begin
            wr(A_CTRL, 32'h2 | (32'(i) << 2));
            rd(A_CTRL, 32'h3ff, 32'h2 | (32'(i) << 2));
        end
        // Parameters first, enable last
        wr(A_BEGINH, 32'h0);
        wr(A_BEGIN, 32'd1000);
        wr(A_END, 32'd5000);
        wr(A_TIME, 32'h1);
        wr(A_CTRL, 32'h208);
        rd(A_CTRL, 32'h3ff, 32'h208);
        wr(A_CTRL, 32'h209);
        rd(A_CTRL, 32'h3ff, 32'h009);
        wr(A_IMASK, 32'h0);
        wr(A_STAT, 32'h7);
        repeat (4) @(posedge pclk);
        cmp_pin("freq_out", 35'd1000, freq_out);
        wr(A_CMD, 32'h5);
        wr(A_CMD, 32'h2);
        c0 = cyc;
        rd(A_STAT, 32'h1f, 32'h04);
        cmp_pin("wai_stall", 35'h1, 35'((cyc - c0) > 50000));
        rd(A_STAT, 32'h1f, 32'h17);
        cmp_pin("freq_out", 35'd1000, freq_out);
        cmp_pin("irq", 35'h0, 35'(irq));
        wr(A_IMASK, 32'h2);
        @(posedge pclk);
        cmp_pin("irq", 35'h1, 35'(irq));
        wr(A_STAT, 32'h2);
        @(posedge pclk);
        cmp_pin("irq", 35'h0, 35'(irq));
        wr(A_STAT, 32'h7);
        wr(A_CTRL, 32'h5);
        repeat (4) @(posedge pclk);
        cmp_pin("lamp", 35'h1, 35'(trig_wait_lamp));
        ext_fire <= 1'b1;
        @(posedge pclk);
        ext_fire <= 1'b0;
        repeat (12) @(posedge pclk);
        cmp_pin("lamp", 35'h0, 35'(trig_wait_lamp));
        rd(A_STAT, 32'h4, 32'h4);
        wr(A_CMD, 32'h8);
        rd(A_CTRL, 32'hc, 32'h0);
        final_report();
    end
endmodule : frequency_sweep_controller_tb_top
